//--- design/fast_slew_map.svh
// Register indices, byte addresses, reset values and fixed codes for the fast-slew control block.
// Assumes an APB slave with 32-bit data and one aligned word for each register.
`ifndef FAST_SLEW_MAP_SVH
`define FAST_SLEW_MAP_SVH

// Register indices. The byte address is four times the index.
`define SENSE_TIMER_COUNT_INDEX  10'h0a7
`define FAST_SLEW_CONTROL_INDEX  10'h0a8
`define SENSE_CONTROL_TWO_INDEX  10'h0a9

// Reset values of the registers.
`define SENSE_TIMER_COUNT_RESET  6'h00
`define FAST_SLEW_CONTROL_RESET  8'h00
`define CURRENT_RANGE_RESET      2'h0

// Highest current-range code, forced while the boost interval runs.
`define MAX_CURRENT_RANGE        2'h3

// Width of the boost interval counter.
`define BOOST_INTERVAL_WIDTH     7

// Byte lane that carries the register data.
`define DATA_LANE                0

`endif

//--- design/fast_slew_pkg.sv
// Types used by the fast-slew control block, not by its counter.
// Field layouts follow the register map header; nothing here is a process.
package fast_slew_pkg;

  // Fast-slew control word: interval in bits 7..1, enable in bit 0.
  typedef struct packed {
    logic [6:0] boost_interval_length;
    logic       boost_enable;
  } fast_slew_control_type;

  // Sense timer word: count in bits 5..0, upper bits read as zero.
  typedef struct packed {
    logic [1:0] spare;
    logic [5:0] timer_count_value;
  } sense_timer_count_type;

  // Sense control word: range in bits 1..0, boost status in bit 7.
  typedef struct packed {
    logic       boost_active;
    logic [4:0] spare;
    logic [1:0] oscillator_current_range;
  } sense_control_two_type;

  // Register selected by an APB address.
  typedef enum {
    select_none,
    select_timer,
    select_slew,
    select_control
  } register_select_type;

endpackage : fast_slew_pkg

//--- design/boost_interval_counter.sv
// Down-counter that times the forced-maximum current interval.
// Assumes load is a one-cycle pulse on the same clock as pclk.
`timescale 1ns/100ps

module boost_interval_counter #(
  parameter int WIDTH = 7
) (
  input  wire logic             pclk,        // Internal main clock.
  input  wire logic             presetn,     // Asynchronous reset, active low.
  input  wire logic             enable,      // Counting allowed while high.
  input  wire logic             load,        // Reload pulse from an oscillator edge.
  input  wire logic [WIDTH-1:0] load_value,  // Interval length in clock periods.
  output logic                  active,      // High while the count is above zero.
  output logic [WIDTH-1:0]      count        // Present count value.
);

  logic [WIDTH-1:0] next_count;

  // A low enable clears the count at the next pclk edge, so a disabled boost stops forcing the range.
  always_comb begin
    next_count = count;
    if (!enable) begin
      next_count = '0;
    end else if (load) begin
      next_count = load_value;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  // Count register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // A loaded zero gives no interval at all.
  assign active = (count != '0);

endmodule : boost_interval_counter

//--- design/fast_slew_interval_control.sv
// Fast-slew control for a relaxation oscillator, with the sense timer count register.
// Assumes pclk is the internal main clock and that the oscillator output is asynchronous
// to it. Registers are reached over APB with zero wait states.
`timescale 1ns/100ps

`include "fast_slew_map.svh"

// How it works
// RULE1: Interval field loads counter on main clock.
// RULE2: Counting forces current range to maximum.
// RULE3: Interval end restores programmed current range.
// RULE4: Enable low passes programmed range through.
// RULE5: Every oscillator edge reloads the counter.
// RULE6: Range field reads back programmed value only.
// RULE7: Zero gives none, N gives N periods.
// RULE8: Six-bit timer count, reset to zero.
// RULE9: Synchronise oscillator, detect both edges.
module fast_slew_interval_control #(
  parameter int ADDR_WIDTH = 12,
  parameter int SYNC_DEPTH = 2
) (
  input  wire logic                  pclk,                  // Internal main clock, 25 MHz.
  input  wire logic                  presetn,               // Asynchronous reset, active low.
  input  wire logic                  psel,                  // APB select.
  input  wire logic                  penable,               // APB access phase.
  input  wire logic                  pwrite,                // APB direction, high for write.
  input  wire logic [ADDR_WIDTH-1:0] paddr,                 // APB byte address.
  input  wire logic [31:0]           pwdata,                // APB write data.
  input  wire logic [3:0]            pstrb,                 // APB write byte strobes.
  output logic [31:0]                prdata,                // APB read data.
  output logic                       pready,                // APB ready.
  output logic                       pslverr,               // APB error on unmapped address.
  input  wire logic                  relax_osc_out,         // Relaxation oscillator output.
  output logic [1:0]                 effective_current_range, // Range sent to the oscillator.
  output logic                       boost_active,          // Forced interval in progress.
  output logic [5:0]                 timer_count_value      // Sense timer count.
);

  // Byte address of a register from its index.
  function automatic logic [ADDR_WIDTH-1:0] byte_address(input logic [9:0] index);
    byte_address = ADDR_WIDTH'({index, 2'h0});
  endfunction : byte_address

  // Register selected by an address; anything else is unmapped.
  function automatic fast_slew_pkg::register_select_type decode(
    input logic [ADDR_WIDTH-1:0] addr
  );
    if (addr == byte_address(`SENSE_TIMER_COUNT_INDEX)) begin
      decode = fast_slew_pkg::select_timer;
    end else if (addr == byte_address(`FAST_SLEW_CONTROL_INDEX)) begin
      decode = fast_slew_pkg::select_slew;
    end else if (addr == byte_address(`SENSE_CONTROL_TWO_INDEX)) begin
      decode = fast_slew_pkg::select_control;
    end else begin
      decode = fast_slew_pkg::select_none;
    end
  endfunction : decode

  // Software-visible register state.
  fast_slew_pkg::fast_slew_control_type slew_control;
  fast_slew_pkg::fast_slew_control_type next_slew_control;
  logic [5:0]                           timer_count;
  logic [5:0]                           next_timer_count;
  logic [1:0]                           user_range;
  logic [1:0]                           next_user_range;

  // Bus response state.
  logic [31:0]                          next_prdata;
  logic                                 next_pslverr;

  // Oscillator synchroniser and edge detector.
  logic [SYNC_DEPTH-1:0]                osc_sync;
  logic [SYNC_DEPTH-1:0]                next_osc_sync;
  logic                                 osc_last;
  logic                                 next_osc_last;
  logic                                 osc_edge;

  // Effective range output state.
  logic [1:0]                           next_effective_range;
  logic                                 next_boost_active;
  logic                                 counter_active;

  fast_slew_pkg::register_select_type   setup_select;
  fast_slew_pkg::register_select_type   access_select;
  logic                                 setup_phase;
  logic                                 write_strobe;
  fast_slew_pkg::sense_timer_count_type timer_word;
  fast_slew_pkg::sense_control_two_type control_word;

  // Every transfer completes in its first access cycle, so no wait state is needed.
  assign pready       = psel & penable;
  assign setup_phase  = psel & ~penable;
  assign setup_select = decode(paddr);
  assign access_select = decode(paddr);
  // Data sits in the low byte lane; a write without that strobe changes nothing.
  assign write_strobe = psel & penable & pwrite & pstrb[`DATA_LANE];

  // Read words, built from register state so reserved bits read as zero.
  always_comb begin
    timer_word                   = '0;
    timer_word.timer_count_value = timer_count;
    control_word                 = '0;
    control_word.oscillator_current_range = user_range; // RULE6
    control_word.boost_active    = boost_active;
  end

  // Read data and error are captured in the setup cycle so both come from flip-flops.
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup_phase) begin
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      case (setup_select)
        fast_slew_pkg::select_timer: begin
          next_prdata[7:0] = timer_word;
        end
        fast_slew_pkg::select_slew: begin
          next_prdata[7:0] = slew_control;
        end
        fast_slew_pkg::select_control: begin
          next_prdata[7:0] = control_word;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Register writes take effect at the edge that ends the access phase.
  // Unmapped writes are dropped; the error flag already tells the master.
  always_comb begin
    next_slew_control = slew_control;
    next_timer_count  = timer_count;
    next_user_range   = user_range;
    if (write_strobe) begin
      case (access_select)
        fast_slew_pkg::select_timer: begin
          next_timer_count = pwdata[5:0]; // RULE8
        end
        fast_slew_pkg::select_slew: begin
          next_slew_control = fast_slew_pkg::fast_slew_control_type'(pwdata[7:0]);
        end
        fast_slew_pkg::select_control: begin
          next_user_range = pwdata[1:0];
        end
        default: begin
          next_user_range = user_range;
        end
      endcase
    end
  end

  // Power-on reset clears both documented registers and the programmed range.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_control <= fast_slew_pkg::fast_slew_control_type'(`FAST_SLEW_CONTROL_RESET);
      timer_count  <= `SENSE_TIMER_COUNT_RESET; // RULE8
      user_range   <= `CURRENT_RANGE_RESET;
    end else begin
      slew_control <= next_slew_control;
      timer_count  <= next_timer_count;
      user_range   <= next_user_range;
    end
  end

  assign timer_count_value = timer_count;

  // The oscillator is asynchronous to pclk. The first stage feeds only the second,
  // and the edge detector looks at the settled stage and one stage behind it.
  always_comb begin
    next_osc_sync = {osc_sync[SYNC_DEPTH-2:0], relax_osc_out}; // RULE9
    next_osc_last = osc_sync[SYNC_DEPTH-1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync <= '0;
      osc_last <= 1'b0;
    end else begin
      osc_sync <= next_osc_sync;
      osc_last <= next_osc_last;
    end
  end

  // Rising and falling edges both restart the boost interval.
  assign osc_edge = osc_sync[SYNC_DEPTH-1] ^ osc_last; // RULE9

  // The counter loads the interval field on each edge and counts on pclk.
  // With the enable low it is held at zero and the field has no effect.
  boost_interval_counter #(
    .WIDTH      (`BOOST_INTERVAL_WIDTH)
  ) interval_counter (
    .pclk       (pclk),
    .presetn    (presetn),
    .enable     (slew_control.boost_enable),           // RULE4
    .load       (osc_edge),                            // RULE5
    .load_value (slew_control.boost_interval_length),  // RULE1
    .active     (counter_active),                      // RULE7
    .count      ()
  );

  // The range output is registered so the oscillator sees no decode glitches.
  // This costs one cycle of lag, but the forced interval keeps its exact length.
  always_comb begin
    next_boost_active = counter_active;
    if (counter_active) begin
      next_effective_range = `MAX_CURRENT_RANGE; // RULE2
    end else begin
      next_effective_range = user_range; // RULE3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      effective_current_range <= `CURRENT_RANGE_RESET;
      boost_active            <= 1'b0;
    end else begin
      effective_current_range <= next_effective_range;
      boost_active            <= next_boost_active;
    end
  end

endmodule : fast_slew_interval_control

//--- sim/fast_slew_checker_assertions.sv
// Assertions on the ports of the fast-slew control block.
// Assumes zero-wait APB and the addresses of the register map header.
`timescale 1ns/100ps
`include "fast_slew_map.svh"
module fast_slew_checker #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic                  pclk, // Clock.
  input wire logic                  presetn, // Reset.
  input wire logic                  psel, // Select.
  input wire logic                  penable, // Access.
  input wire logic                  pwrite, // Write.
  input wire logic [ADDR_WIDTH-1:0] paddr, // Address.
  input wire logic [31:0]           pwdata, // Write data.
  input wire logic [3:0]            pstrb, // Strobes.
  input wire logic [31:0]           prdata, // Read data.
  input wire logic                  pready, // Ready.
  input wire logic                  pslverr, // Error.
  input wire logic                  relax_osc_out, // Oscillator.
  input wire logic [1:0]            effective_current_range, // Range out.
  input wire logic                  boost_active, // Boost.
  input wire logic [5:0]            timer_count_value // Timer.
);
  localparam logic [11:0] A_TIM = {`SENSE_TIMER_COUNT_INDEX, 2'h0};
  localparam logic [11:0] A_SLW = {`FAST_SLEW_CONTROL_INDEX, 2'h0};
  localparam logic [11:0] A_CTL = {`SENSE_CONTROL_TWO_INDEX, 2'h0};
  typedef struct packed {
    logic [5:0] tim;
    logic [7:0] slew;
    logic [1:0] rng;
    logic       osc;
    logic [7:0] run;
  } shadow_type;
  shadow_type sh;
  shadow_type next_sh;
  logic       acc;
  logic       wr;
  logic       mapped;
  logic [7:0] rd_exp;
  // Bus decode; unmapped places must read as zero.
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign mapped = paddr == A_TIM || paddr == A_SLW || paddr == A_CTL;
  assign rd_exp = !mapped ? 8'h00 : paddr == A_TIM ? {2'h0, sh.tim} :
                  paddr == A_SLW ? sh.slew : {6'h00, sh.rng};
  // Shadow registers; the run count restarts at an input change, since that reloads.
  always_comb begin
    next_sh = sh;
    if (wr && paddr == A_TIM) next_sh.tim = pwdata[5:0];
    if (wr && paddr == A_SLW) next_sh.slew = pwdata[7:0];
    if (wr && paddr == A_CTL) next_sh.rng = pwdata[1:0];
    next_sh.osc = relax_osc_out;
    next_sh.run = (!boost_active || relax_osc_out != sh.osc) ? 8'h00 : sh.run + 8'h01;
  end
  // Registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh <= '0;
    else sh <= next_sh;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An input change while boosting is enabled with a nonzero interval.
  sequence s_edge;
    relax_osc_out != sh.osc && sh.slew[0] && sh.slew[7:1] != 7'h00 && $stable(sh.slew);
  endsequence
  // Interval zero for four cycles and nothing running.
  sequence s_idle_zero;
    (sh.slew[7:1] == 7'h00) [*4] ##0 !boost_active;
  endsequence
  AST_FORCE_MAX: assert property (boost_active |-> effective_current_range == 2'h3)
    else $error("range not forced");
  AST_EDGE_BOOST: assert property (s_edge |-> ##[3:5] boost_active)
    else $error("edge did not start boost");
  AST_PASS_RANGE: assert property (!boost_active && $stable(sh.rng) && sh.rng == $past(sh.rng, 2)
    |-> effective_current_range == sh.rng)
    else $error("range not restored");
  AST_ENABLE_OFF: assert property (!sh.slew[0] && !$past(sh.slew[0]) && !$past(sh.slew[0], 2)
    |-> !boost_active)
    else $error("boost while disabled");
  AST_ZERO_NONE: assert property (s_idle_zero |=> !boost_active) else $error("zero boosted");
  AST_RUN_BOUND: assert property (boost_active |-> sh.run <= {1'b0, sh.slew[7:1]} + 8'h04)
    else $error("boost too long");
  AST_TIMER: assert property (timer_count_value == sh.tim) else $error("timer wrong");
  AST_READY: assert property (acc |-> pready) else $error("wait state");
  AST_SLVERR: assert property (acc |-> pslverr == !mapped) else $error("error flag wrong");
  AST_READ_BACK: assert property (acc && !pwrite |->
    (prdata & {24'hffffff, paddr != A_CTL, 7'h7f}) == {24'h000000, rd_exp})
    else $error("read data wrong");
endmodule : fast_slew_checker
bind fast_slew_interval_control fast_slew_checker #(.ADDR_WIDTH(ADDR_WIDTH)) watch (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .relax_osc_out, .effective_current_range, .boost_active, .timer_count_value);

//--- sim/relax_osc_model.sv
// Behavioural relaxation oscillator at the far side of the block.
// Assumes the bench gives the half period in ns and starts it on a clock edge.
`timescale 1ns/100ps
module relax_osc_model (
  input wire logic        run, // Oscillate while high.
  input wire logic [15:0] half_ns, // Half period.
  output logic            relax_osc_out // Comparator output.
);
  // The 13 ns lag keeps toggles off the clock edge; stopped, it holds its level.
  initial relax_osc_out = 1'b0;
  always begin
    wait (run);
    #13;
    while (run) #(half_ns) relax_osc_out = !relax_osc_out;
  end
endmodule : relax_osc_model

//--- sim/fast_slew_interval_control_bench.sv
// Self-checking bench for the fast-slew control block.
// Assumes the checker is bound in and the oscillator model drives the input.
`timescale 1ns/100ps
`include "fast_slew_map.svh"
module fast_slew_interval_control_bench;
  localparam logic [11:0] A_TIM = {`SENSE_TIMER_COUNT_INDEX, 2'h0};
  localparam logic [11:0] A_SLW = {`FAST_SLEW_CONTROL_INDEX, 2'h0};
  localparam logic [11:0] A_CTL = {`SENSE_CONTROL_TWO_INDEX, 2'h0};
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [3:0]  strb;
    logic [8:0]  want; // Error flag above the read byte.
  } row_type;
  // Write then read back; a zero strobe and an unmapped place are among them.
  row_type     rows [6] = '{'{A_TIM, 8'hff, 4'hf, 9'h03f}, '{A_SLW, 8'ha5, 4'h1, 9'h0a5},
    '{A_SLW, 8'h5a, 4'h0, 9'h0a5}, '{A_CTL, 8'h86, 4'h1, 9'h002},
    '{12'h2a8, 8'h55, 4'hf, 9'h100}, '{A_TIM, 8'h2a, 4'h1, 9'h02a}};
  logic [11:0] regs [3] = '{A_TIM, A_SLW, A_CTL};
  logic [6:0]  lens [3] = '{7'h01, 7'h05, 7'h7f};
  logic [7:0]  quiet [2] = '{8'hfe, 8'h01};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, run, boost_active, err;
  logic        relax_osc_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] half_ns;
  logic [1:0]  effective_current_range;
  logic [5:0]  timer_count_value;
  int          n_fail = 0, checked = 0, i, k;
  fast_slew_interval_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .relax_osc_out, .effective_current_range,
    .boost_active, .timer_count_value);
  relax_osc_model osc (.run, .half_ns, .relax_osc_out);
  // Main clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = !pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic test_done();
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // The run takes some 2,300 cycles; about thirteen times that means a hang.
  initial begin
    #(40 * 30000);
    n_fail++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, run} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    half_ns = 16'h1f40;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[j]) begin
      apb(1'b0, regs[j], 8'h00, 4'h0);
      chk(rd, 32'h00000000);
    end
    foreach (rows[j]) begin
      apb(1'b1, rows[j].addr, rows[j].wdata, rows[j].strb);
      apb(1'b0, rows[j].addr, 8'h00, 4'h0);
      chk(rd, {24'h000000, rows[j].want[7:0]});
      chk({31'h00000000, err}, {31'h00000000, rows[j].want[8]});
    end
    // Boost length at the shortest, a middle and the longest interval.
    foreach (lens[j]) begin
      apb(1'b1, A_CTL, 8'h01, 4'h1);
      apb(1'b1, A_SLW, {lens[j], 1'b1}, 4'h1);
      run <= 1'b1;
      for (i = 0; boost_active !== 1'b1 && i < 600; i++) @(posedge pclk);
      chk({30'h0, effective_current_range}, 32'h00000003);
      for (k = 0; boost_active === 1'b1 && k < 300; k++) @(posedge pclk);
      chk(k, {25'h0000000, lens[j]});
      chk({30'h00000000, effective_current_range}, 32'h00000001);
      run <= 1'b0;
      repeat (400) @(posedge pclk);
    end
    // Disabled, and enabled with a zero interval: no boost at any edge.
    half_ns = 16'h0190;
    foreach (quiet[j]) begin
      apb(1'b1, A_SLW, quiet[j], 4'h1);
      run <= 1'b1;
      k = 0;
      repeat (100) begin
        @(posedge pclk);
        if (boost_active !== 1'b0) k++;
      end
      run <= 1'b0;
      chk(k, 32'h00000000);
    end
    // Edges closer than the interval keep the boost on without a gap.
    apb(1'b1, A_SLW, 8'h29, 4'h1);
    run <= 1'b1;
    repeat (40) @(posedge pclk);
    k = 0;
    repeat (60) begin
      @(posedge pclk);
      if (boost_active !== 1'b1) k++;
    end
    chk(k, 32'h00000000);
    apb(1'b0, A_CTL, 8'h00, 4'h0);
    chk(rd, 32'h00000081);
    chk({26'h0, timer_count_value}, 32'h0000002a);
    // Reset in mid-boost clears outputs and registers at once.
    presetn <= 1'b0;
    run <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk({23'h000000, boost_active, effective_current_range, timer_count_value}, 32'h0);
    presetn <= 1'b1;
    test_done();
  end
endmodule : fast_slew_interval_control_bench
